/* File: rtl/ind_addr_pkg.sv */
// shared types and constants for the indirect pointer addressing unit
package ind_addr_pkg;

  // data memory geometry
  localparam int DATA_ADDR_W = 12;
  localparam int MEM_DEPTH   = 4096;

  // register index = byte offset / 4; bit 3 picks the pair, bits 2:0 the slot
  localparam logic [4:0] IDX_PLAIN_PORT_ONE   = 5'h00;
  localparam logic [4:0] IDX_POSTINC_PORT_ONE = 5'h01;
  localparam logic [4:0] IDX_POSTDEC_PORT_ONE = 5'h02;
  localparam logic [4:0] IDX_PREINC_PORT_ONE  = 5'h03;
  localparam logic [4:0] IDX_OFFSET_PORT_ONE  = 5'h04;
  localparam logic [4:0] IDX_POINTER1_HIGH    = 5'h05;
  localparam logic [4:0] IDX_POINTER1_LOW     = 5'h06;
  localparam logic [4:0] IDX_BANK_SELECT      = 5'h07;
  localparam logic [4:0] IDX_PLAIN_PORT_TWO   = 5'h08;
  localparam logic [4:0] IDX_POSTINC_PORT_TWO = 5'h09;
  localparam logic [4:0] IDX_POSTDEC_PORT_TWO = 5'h0A;
  localparam logic [4:0] IDX_PREINC_PORT_TWO  = 5'h0B;
  localparam logic [4:0] IDX_OFFSET_PORT_TWO  = 5'h0C;
  localparam logic [4:0] IDX_POINTER2_HIGH    = 5'h0D;
  localparam logic [4:0] IDX_POINTER2_LOW     = 5'h0E;
  localparam logic [4:0] IDX_ARITH_FLAGS      = 5'h0F;
  localparam logic [4:0] IDX_WORK_REG         = 5'h10;
  localparam logic [4:0] REG_COUNT            = 5'h11;
  localparam int         PAIR_BIT             = 3;

  // the same registers seen from data memory: address = base + index
  localparam logic [11:0] SFR_BASE  = 12'hFE0;
  localparam logic [11:0] SFR_LIMIT = 12'hFF1;

  // reset values
  localparam logic [3:0] PTR_HIGH_RST = 4'h0;
  localparam logic [7:0] PTR_LOW_RST  = 8'h00;
  localparam logic [3:0] BANK_RST     = 4'h0;
  localparam logic [4:0] FLAGS_RST    = 5'h00;
  localparam logic [7:0] WREG_RST     = 8'h00;

  // slot within a pair
  typedef enum logic [2:0] {
    SLOT_PLAIN   = 3'b000,
    SLOT_POSTINC = 3'b001,
    SLOT_POSTDEC = 3'b010,
    SLOT_PREINC  = 3'b011,
    SLOT_OFFSET  = 3'b100,
    SLOT_HIGH    = 3'b101,
    SLOT_LOW     = 3'b110,
    SLOT_MISC    = 3'b111
  } slot_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01,
    ST_DONE = 2'b10
  } phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    phase_t      phase;
    logic [11:0] ptr_one;
    logic [11:0] ptr_two;
    logic [3:0]  bank;
    logic [4:0]  flags;
    logic [7:0]  wreg;
    logic [7:0]  rdata;
    logic        err;
  } core_state_t;

  localparam core_state_t STATE_RST = '{
    phase:   ST_IDLE,
    ptr_one: {PTR_HIGH_RST, PTR_LOW_RST},
    ptr_two: {PTR_HIGH_RST, PTR_LOW_RST},
    bank:    BANK_RST,
    flags:   FLAGS_RST,
    wreg:    WREG_RST,
    rdata:   8'h00,
    err:     1'b0
  };

endpackage : ind_addr_pkg

/* File: rtl/data_mem.sv */
// byte-wide data memory with registered read data
`timescale 1ns/100ps
module data_mem (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire ind_addr_pkg::mem_req_t mem_req,
  output logic [7:0]                  rdata
);
  import ind_addr_pkg::*;

  logic [7:0] cells [0:MEM_DEPTH-1];

  // array has no reset; contents are whatever software left there
  always_ff @(posedge core_clk) begin
    if (mem_req.we) begin
      cells[mem_req.addr] <= mem_req.wdata;
    end
  end

  // read data one edge after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (mem_req.re) begin
      rdata <= cells[mem_req.addr];
    end
  end

endmodule : data_mem

/* File: rtl/indirect_pointer_addressing.sv */
// indirect addressing unit: pointer pairs one and two, virtual ports, bank select
`timescale 1ns/100ps
module indirect_pointer_addressing (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire ind_addr_pkg::apb_req_t apb_req,
  output ind_addr_pkg::apb_rsp_t      apb_rsp,
  output logic [11:0]                 pointer_pair_one,
  output logic [11:0]                 pointer_pair_two,
  output logic [7:0]                  bank_select
);
  import ind_addr_pkg::*;

  core_state_t state;
  core_state_t next_state;
  mem_req_t    mem_req;
  logic [7:0]  mem_rdata;

  // true for the five address-generating ports of either pair
  function automatic logic is_virtual(input logic [4:0] idx);
    logic v;
    v = (idx < IDX_WORK_REG) && (idx[2:0] <= SLOT_OFFSET);
    return v;
  endfunction : is_virtual

  // read view of a register by index
  function automatic logic [7:0] reg_value(input core_state_t st, input logic [4:0] idx);
    logic [7:0]  v;
    logic [11:0] p;
    v = 8'h00;
    p = 12'h000;
    if (idx == IDX_WORK_REG) begin
      v = st.wreg;
    end else if (idx < REG_COUNT) begin
      case (slot_t'(idx[2:0]))
        SLOT_HIGH: begin
          // the upper nibble does not exist and reads zero
          p = pair_value(st, idx[PAIR_BIT]);
          v = {4'h0, p[11:8]};
        end
        SLOT_LOW: begin
          p = pair_value(st, idx[PAIR_BIT]);
          v = p[7:0];
        end
        SLOT_MISC: begin
          if (idx[PAIR_BIT]) begin
            v = {3'h0, st.flags};
          end else begin
            v = {4'h0, st.bank};
          end
        end
        default:   v = 8'h00;
      endcase
    end
    return v;
  endfunction : reg_value

  // write a register by index; virtual slots hold nothing
  function automatic core_state_t write_reg(input core_state_t st,
                                            input logic [4:0]  idx,
                                            input logic [7:0]  d);
    core_state_t r;
    r = st;
    if (idx == IDX_WORK_REG) begin
      r.wreg = d;
    end else if (idx < REG_COUNT) begin
      case (slot_t'(idx[2:0]))
        SLOT_HIGH: begin
          // only the low nibble exists
          if (idx[PAIR_BIT]) begin
            r.ptr_two[11:8] = d[3:0];
          end else begin
            r.ptr_one[11:8] = d[3:0];
          end
        end
        SLOT_LOW: begin
          if (idx[PAIR_BIT]) begin
            r.ptr_two[7:0] = d;
          end else begin
            r.ptr_one[7:0] = d;
          end
        end
        SLOT_MISC: begin
          // flags keep five bits, bank select four
          if (idx[PAIR_BIT]) begin
            r.flags = d[4:0];
          end else begin
            r.bank = d[3:0];
          end
        end
        default: r = st;
      endcase
    end
    return r;
  endfunction : write_reg

  // refused requests: upper half, misaligned or beyond the last register
  function automatic logic is_refused(input apb_req_t rq);
    logic bad;
    bad = 1'b0;
    if (rq.paddr[7]) begin
      bad = 1'b1;
    end
    if (rq.paddr[1:0] != 2'b00) begin
      bad = 1'b1;
    end
    if (rq.paddr[6:2] >= REG_COUNT) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : is_refused

  // current value of the pair picked by the pair bit
  function automatic logic [11:0] pair_value(input core_state_t st, input logic pair);
    logic [11:0] v;
    if (pair) begin
      v = st.ptr_two;
    end else begin
      v = st.ptr_one;
    end
    return v;
  endfunction : pair_value

  // load the pair picked by the pair bit, the other one untouched
  function automatic core_state_t set_pair(input core_state_t st,
                                           input logic        pair,
                                           input logic [11:0] v);
    core_state_t r;
    r = st;
    if (pair) begin
      r.ptr_two = v;
    end else begin
      r.ptr_one = v;
    end
    return r;
  endfunction : set_pair

  // pointer value after the access; full twelve bits, wraps at both ends
  function automatic logic [11:0] step_ptr(input logic [11:0] p, input slot_t s);
    logic [11:0] n;
    n = p;
    case (s)
      SLOT_POSTINC: begin
        n = p + 12'h001;
      end
      SLOT_POSTDEC: begin
        n = p - 12'h001;
      end
      SLOT_PREINC: begin
        n = p + 12'h001;
      end
      default: begin
        n = p;
      end
    endcase
    return n;
  endfunction : step_ptr

  // effective data memory address of a virtual port access
  function automatic logic [11:0] eff_addr(input logic [11:0] p,
                                           input slot_t       s,
                                           input logic [7:0]  w);
    logic [11:0] a;
    a = p;
    case (s)
      SLOT_PREINC: begin
        a = p + 12'h001;
      end
      SLOT_OFFSET: begin
        // unsigned offset; the sum wraps inside the address space
        a = p + {4'h0, w};
      end
      default: begin
        a = p;
      end
    endcase
    return a;
  endfunction : eff_addr

  // true when an effective address falls on the register window
  function automatic logic in_window(input logic [11:0] a);
    logic hit;
    hit = (a >= SFR_BASE) && (a < SFR_LIMIT);
    return hit;
  endfunction : in_window

  // register index behind a window address
  function automatic logic [4:0] window_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - SFR_BASE;
    return rel[4:0];
  endfunction : window_index

  // a target on the accessing pair's own high or low byte
  function automatic logic own_byte(input logic [4:0] t, input logic pair);
    logic hit;
    hit = 1'b0;
    if ((t < IDX_WORK_REG) && (t[PAIR_BIT] == pair)) begin
      hit = (t[2:0] == SLOT_HIGH) || (t[2:0] == SLOT_LOW);
    end
    return hit;
  endfunction : own_byte

  // memory request for a redirected access; read and write never both
  function automatic mem_req_t mem_access(input logic [11:0] a,
                                          input logic        w,
                                          input logic [7:0]  d);
    mem_req_t m;
    m       = '0;
    m.addr  = a;
    m.wdata = d;
    m.we    = w;
    m.re    = !w;
    return m;
  endfunction : mem_access

  // access that lands on the register window instead of memory
  function automatic core_state_t window_access(input core_state_t nx,
                                                input core_state_t cur,
                                                input logic [4:0]  t,
                                                input logic        w,
                                                input logic [7:0]  d);
    core_state_t r;
    r = nx;
    if (is_virtual(t)) begin
      // a port reached through a port holds nothing: zero, write dropped
      r.rdata = 8'h00;
    end else if (w) begin
      r = write_reg(nx, t, d);
    end else begin
      r.rdata = reg_value(cur, t);
    end
    return r;
  endfunction : window_access

  // access decode, address generation and pointer stepping
  always_comb begin
    logic [4:0]  idx;
    logic [4:0]  tidx;
    logic [11:0] ptr;
    logic [11:0] new_ptr;
    logic [11:0] ea;
    logic        sfr_hit;
    logic        own_pair;
    logic        skip_step;
    idx        = apb_req.paddr[6:2];
    tidx       = 5'h00;
    ptr        = 12'h000;
    new_ptr    = 12'h000;
    ea         = 12'h000;
    sfr_hit    = 1'b0;
    own_pair   = 1'b0;
    skip_step  = 1'b0;
    next_state = state;
    mem_req    = '0;
    case (state.phase)
      ST_IDLE: begin
        if (apb_req.psel && apb_req.penable) begin
          next_state.phase = ST_DONE;
          next_state.err   = 1'b0;
          next_state.rdata = 8'h00;
          if (is_refused(apb_req)) begin
            // unmapped or misaligned: error answer, nothing changes
            next_state.err = 1'b1;
          end else if (!is_virtual(idx)) begin
            if (apb_req.pwrite) begin
              next_state = write_reg(next_state, idx, apb_req.pwdata[7:0]);
            end else begin
              next_state.rdata = reg_value(state, idx);
            end
          end else begin
            ptr     = pair_value(state, idx[PAIR_BIT]);
            new_ptr = step_ptr(ptr, slot_t'(idx[2:0]));
            ea      = eff_addr(ptr, slot_t'(idx[2:0]), state.wreg);
            // does the effective address land on one of our own registers
            sfr_hit  = in_window(ea);
            tidx     = window_index(ea);
            own_pair = sfr_hit && own_byte(tidx, idx[PAIR_BIT]);
            // a write onto its own pair keeps the written value, not the step
            skip_step = own_pair && apb_req.pwrite;
            if (!skip_step) begin
              next_state = set_pair(next_state, idx[PAIR_BIT], new_ptr);
            end
            if (sfr_hit) begin
              next_state = window_access(next_state, state, tidx, apb_req.pwrite,
                                         apb_req.pwdata[7:0]);
            end else begin
              // redirect to memory; the port itself keeps nothing
              mem_req = mem_access(ea, apb_req.pwrite, apb_req.pwdata[7:0]);
              if (!apb_req.pwrite) begin
                next_state.phase = ST_MEM;
              end
            end
          end
        end
      end
      ST_MEM: begin
        // memory data arrives one edge after the read was issued
        next_state.rdata = mem_rdata;
        next_state.phase = ST_DONE;
      end
      ST_DONE: begin
        next_state.phase = ST_IDLE;
      end
      default: begin
        next_state.phase = ST_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= STATE_RST;
    end else begin
      state <= next_state;
    end
  end

  data_mem u_data_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .mem_req  (mem_req),
    .rdata    (mem_rdata)
  );

  // answer comes from registered state; ready only in the last phase
  assign apb_rsp = '{
    pready:  (state.phase == ST_DONE),
    prdata:  {24'h00_0000, state.rdata},
    pslverr: (state.phase == ST_DONE) && state.err
  };

  // per-pair views for the core's direct addressing path
  logic [11:0] pair_view [0:1];

  for (genvar g = 0; g < 2; g++) begin : g_pair
    // both pairs leave straight from the state register, no extra stage
    assign pair_view[g] = pair_value(state, (g != 0));
  end

  assign pointer_pair_one = pair_view[0];
  assign pointer_pair_two = pair_view[1];
  // upper nibble of the bank byte is not stored
  assign bank_select      = {4'h0, state.bank};

endmodule : indirect_pointer_addressing

/* File: sim/ind_addr_asserts.sv */
// checker for the indirect pointer addressing unit
`timescale 1ns/100ps
module ind_addr_asserts (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire ind_addr_pkg::apb_req_t apb_req,
  input wire ind_addr_pkg::apb_rsp_t apb_rsp,
  input wire logic [11:0]            pointer_pair_one,
  input wire logic [11:0]            pointer_pair_two,
  input wire logic [7:0]             bank_select
);
  import ind_addr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // first access edge; penable always drops between transfers
  sequence acc_s;
    apb_req.psel && $rose(apb_req.penable);
  endsequence
  // reads only: a write onto the own pair legally skips the step
  sequence rd_s(logic [7:0] a);
    acc_s ##0 (!apb_req.pwrite && apb_req.paddr == a);
  endsequence
  plain_keeps_ptr_a: assert property (rd_s(8'h00) |=> $stable(pointer_pair_one))
    else $error("plain port moved pointer");
  postinc_step_a: assert property (rd_s(8'h04) |=>
    pointer_pair_one == $past(pointer_pair_one) + 12'h001) else $error("no post step");
  postdec_step_a: assert property (rd_s(8'h28) |=>
    pointer_pair_two == $past(pointer_pair_two) - 12'h001) else $error("no post down");
  preinc_step_a: assert property (rd_s(8'h0C) |=>
    pointer_pair_one == $past(pointer_pair_one) + 12'h001) else $error("no pre step");
  offset_keeps_ptr_a: assert property (rd_s(8'h30) |=> $stable(pointer_pair_two))
    else $error("offset port moved pointer");
  answer_time_a: assert property (acc_s |-> ##[1:2] apb_rsp.pready)
    else $error("answer late");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready too long");
  refused_addr_a: assert property (apb_rsp.pready && apb_req.paddr[7] |-> apb_rsp.pslverr)
    else $error("high address taken");
  bank_upper_a: assert property (bank_select[7:4] == 4'h0)
    else $error("bank upper bits set");
endmodule : ind_addr_asserts
bind indirect_pointer_addressing ind_addr_asserts chk (.core_clk, .rst, .apb_req, .apb_rsp,
  .pointer_pair_one, .pointer_pair_two, .bank_select);

/* File: sim/apb_host.sv */
// apb master standing in for the core's execution logic
`timescale 1ns/100ps
module apb_host (
  input  wire logic                   core_clk,
  input  wire ind_addr_pkg::apb_rsp_t apb_rsp,
  output ind_addr_pkg::apb_req_t      apb_req
);
  import ind_addr_pkg::*;
  int timeouts = 0;
  initial apb_req = '0;
  // one transfer; entered just after a rising edge, answer taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
    int n;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) timeouts++;
    r = apb_rsp.prdata[7:0];
    e = apb_rsp.pslverr;
    apb_req <= '0;
    // one idle edge, so a second call never assigns in the same step
    @(posedge core_clk);
  endtask : xfer
endmodule : apb_host

/* File: sim/indirect_pointer_addressing_tb.sv */
// self-checking bench for the indirect pointer addressing unit
`timescale 1ns/100ps
module indirect_pointer_addressing_tb;
  import ind_addr_pkg::*;
  logic        core_clk;
  logic        rst;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  logic [11:0] pointer_pair_one;
  logic [11:0] pointer_pair_two;
  logic [7:0]  bank_select;
  logic [7:0]  rd;
  logic        er;
  int          failures = 0;
  int          comparisons = 0;
  indirect_pointer_addressing uut (.core_clk, .rst, .apb_req, .apb_rsp,
    .pointer_pair_one, .pointer_pair_two, .bank_select);
  apb_host host (.core_clk, .apb_rsp, .apb_req);
  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte
  task automatic cmp_ptr(string what, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_ptr
  // a hung bus ends the run at once
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    host.xfer(w, a, d, rd, er);
    if (host.timeouts != 0) begin
      failures++;
      final_report();
    end
  endtask : acc
  // high byte first, low byte sits one word above
  task automatic setp(logic [7:0] hi_a, logic [11:0] p);
    acc(1'b1, hi_a, {4'h0, p[11:8]});
    acc(1'b1, hi_a + 8'h04, p[7:0]);
  endtask : setp
  task automatic t_regs();
    acc(1'b0, 8'h14, 8'h00);
    cmp_byte("p1 high rst", 8'h00, rd);
    acc(1'b0, 8'h34, 8'h00);
    cmp_byte("p2 high rst", 8'h00, rd);
    acc(1'b1, 8'h14, 8'hF3);
    acc(1'b0, 8'h14, 8'h00);
    cmp_byte("p1 high", 8'h03, rd);
    acc(1'b1, 8'h38, 8'h5A);
    acc(1'b0, 8'h38, 8'h00);
    cmp_byte("p2 low", 8'h5A, rd);
    acc(1'b1, 8'h1C, 8'hFF);
    cmp_byte("bank", 8'h0F, bank_select);
    acc(1'b0, 8'h80, 8'h00);
    cmp_byte("slverr", 8'h01, {7'h00, er});
    acc(1'b0, 8'h19, 8'h00);
    cmp_byte("misaligned", 8'h01, {7'h00, er});
    $display("test regs done");
  endtask : t_regs
  task automatic t_steps();
    setp(8'h14, 12'h120);
    acc(1'b1, 8'h00, 8'hA5);
    cmp_ptr("plain", 12'h120, pointer_pair_one);
    acc(1'b0, 8'h04, 8'h00);
    cmp_byte("postinc data", 8'hA5, rd);
    cmp_ptr("postinc", 12'h121, pointer_pair_one);
    setp(8'h14, 12'h0FF);
    acc(1'b0, 8'h04, 8'h00);
    cmp_ptr("carry", 12'h100, pointer_pair_one);
    setp(8'h14, 12'h11F);
    acc(1'b0, 8'h0C, 8'h00);
    cmp_byte("preinc data", 8'hA5, rd);
    acc(1'b0, 8'h08, 8'h00);
    cmp_byte("postdec one data", 8'hA5, rd);
    cmp_ptr("postdec one", 12'h11F, pointer_pair_one);
    setp(8'h34, 12'h100);
    acc(1'b1, 8'h40, 8'h20);
    acc(1'b0, 8'h30, 8'h00);
    cmp_byte("offset data", 8'hA5, rd);
    acc(1'b1, 8'h40, 8'h01);
    acc(1'b0, 8'h40, 8'h00);
    cmp_byte("work reg", 8'h01, rd);
    acc(1'b0, 8'h10, 8'h00);
    cmp_byte("offset one data", 8'hA5, rd);
    cmp_ptr("offset one", 12'h11F, pointer_pair_one);
    acc(1'b1, 8'h28, 8'h3C);
    cmp_ptr("borrow", 12'h0FF, pointer_pair_two);
    acc(1'b0, 8'h2C, 8'h00);
    cmp_byte("postdec data", 8'h3C, rd);
    acc(1'b0, 8'h28, 8'h00);
    cmp_byte("postdec two data", 8'h3C, rd);
    cmp_ptr("postdec two", 12'h0FF, pointer_pair_two);
    $display("test steps done");
  endtask : t_steps
  task automatic t_cross();
    setp(8'h14, 12'hFE8);
    setp(8'h34, 12'h120);
    acc(1'b0, 8'h00, 8'h00);
    cmp_byte("port via port", 8'h00, rd);
    acc(1'b1, 8'h00, 8'h77);
    acc(1'b0, 8'h20, 8'h00);
    cmp_byte("port write", 8'hA5, rd);
    setp(8'h34, 12'hFED);
    acc(1'b1, 8'h24, 8'h05);
    cmp_ptr("own pair", 12'h5ED, pointer_pair_two);
    $display("test cross done");
  endtask : t_cross
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_steps();
    t_cross();
    final_report();
  end
endmodule : indirect_pointer_addressing_tb
